// >>> rtl/clk_ctrl_pkg.sv
// constants for the clock prescale and start-up control block
package clk_ctrl_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0]  prescale_index     = 8'h61;
   localparam logic [7:0]  trim_index         = 8'h62;
   localparam logic [7:0]  status_index       = 8'h63;
   localparam logic [9:0]  prescale_addr      = {prescale_index, 2'b00};
   localparam logic [9:0]  trim_addr          = {trim_index, 2'b00};
   localparam logic [9:0]  status_addr        = {status_index, 2'b00};
   // prescale register fields
   localparam int          change_enable_bit  = 7;
   localparam logic [3:0]  select_reset_plain = 4'h0;
   localparam logic [3:0]  select_reset_div8  = 4'h3;
   localparam logic [3:0]  select_max         = 4'h8;
   localparam logic [2:0]  change_window      = 3'h4;
   // start-up counts
   localparam int          timeout_short      = 4096;
   localparam int          timeout_long       = 8192;
   localparam logic [3:0]  osc_start_cycles   = 4'h6;
   localparam logic [7:0]  trim_reset         = 8'h00;
   // ahb encodings
   localparam logic [1:0]  htrans_nonseq      = 2'b10;
   localparam logic [2:0]  hsize_word         = 3'b010;

   typedef enum logic [4:0] {
      st_hold      = 5'b00001,
      st_timeout   = 5'b00010,
      st_osc_start = 5'b00100,
      st_run       = 5'b01000,
      st_sleep     = 5'b10000
   } startup_state_t;
endpackage

// >>> rtl/clock_prescale_startup_ctrl.sv
// clock prescaler, clock output, start-up sequencer and oscillator trim with ahb-lite access
//
// Summary of operation
// [RL1] programmed clock output fuse drives divided clock on output pin, overriding port
// [RL2] clock output keeps running while internal reset is held
// [RL3] output pin carries the prescaler-divided clock, not the source clock; at select 0 the pin toggles every cycle, half the divided clock
// [RL4] after other resets release, hold internal reset for watchdog-timed delay
// [RL5] start-up fuses pick 0, 4096 or 8192 watchdog cycles; other codes reserved; code uses 8192 for code 11 and for clock source 01
// [RL6] start counter holds reset a fixed number of oscillator cycles, then releases
// [RL7] reset start applies delay plus start count; power-down wake only start count
// [RL8] factory trim value loads into trim register during chip reset
// [RL9] all eight trim bits writable; 0x00 slowest, 0xff fastest
// [RL10] software keeps trim at or below 8.8 MHz when writing nonvolatile memory
// [RL11] prescale select only accepts writes while change enable is set
// [RL12] setting change enable needs all other register bits written zero
// [RL13] change enable clears four cycles after set, or on select write
// [RL14] setting change enable again neither restarts window nor clears it
// [RL15] prescale bits six to four reserved, read-only, read zero
// [RL16] select n from 0 to 8 divides by two to the n; 9-15 reserved
// [RL17] select resets to 0 or 3 according to divide-by-eight fuse
// [RL18] any select value writable through timed procedure regardless of fuse
// [RL19] divided clock paces processor and all synchronous peripherals
// [RL20] software picks a division keeping system clock within rated maximum
// [RL21] software writes enable alone, then select within four cycles
// [RL22] division change is glitch-free with no period shorter than old or new
// [RL23] fuses are static inputs sampled before internal reset releases
//
// The AHB-Lite interface to the registers is this design's own decision.
module clock_prescale_startup_ctrl #(
   parameter int timeout_short_cycles = clk_ctrl_pkg::timeout_short,
   parameter int timeout_long_cycles  = clk_ctrl_pkg::timeout_long
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        clock_output_fuse,
   input  wire logic [1:0]  clock_source_fuses,
   input  wire logic [1:0]  startup_time_fuses,
   input  wire logic        divide_by_eight_fuse,
   input  wire logic [7:0]  factory_trim,
   input  wire logic        other_reset_active,
   input  wire logic        watchdog_osc_tick,
   input  wire logic        power_down_req,
   input  wire logic        wake_event,
   output logic             internal_reset_n,
   output logic             sys_clk_en,
   output logic             clock_output_pin,
   output logic             clock_output_pin_oe,
   output logic [7:0]       oscillator_trim
);

   // mask of the low n counter bits for a select code, reserved codes held at n of 8
   function automatic logic [7:0] div_mask(input logic [3:0] sel);
      logic [3:0] n;
      n = (sel > clk_ctrl_pkg::select_max) ? clk_ctrl_pkg::select_max : sel;
      div_mask = 8'((9'h001 << n) - 9'h001);
   endfunction

   // watchdog cycles of the time-out for the sampled fuses
   function automatic logic [13:0] timeout_len(input logic [1:0] src, input logic [1:0] sut);
      if (src == 2'b01 || sut == 2'b11)
         timeout_len = 14'(timeout_long_cycles);
      else if (sut == 2'b00)
         timeout_len = 14'h0000;
      else if (sut == 2'b01)
         timeout_len = 14'(timeout_short_cycles);
      else
         timeout_len = 14'(timeout_long_cycles);
   endfunction

   clk_ctrl_pkg::startup_state_t state;
   clk_ctrl_pkg::startup_state_t next_state;

   logic        ph_valid;
   logic        ph_write;
   logic [9:0]  ph_addr;
   logic [3:0]  prescale_select;
   logic        prescale_change_enable;
   logic [2:0]  window_count;
   logic [3:0]  active_select;
   logic        pending_change;
   logic [7:0]  div_count;
   logic [13:0] wdt_count;
   logic [3:0]  osc_count;
   logic [1:0]  fuse_src;
   logic [1:0]  fuse_sut;
   logic        fuse_div8;
   logic        woke_from_sleep;

   // bus decode
   wire         addr_phase   = hsel && hready && htrans == clk_ctrl_pkg::htrans_nonseq
                               && hsize == clk_ctrl_pkg::hsize_word;
   wire         wr_active    = ph_valid && ph_write;
   wire         wr_prescale  = wr_active && ph_addr == clk_ctrl_pkg::prescale_addr;
   wire         wr_trim      = wr_active && ph_addr == clk_ctrl_pkg::trim_addr;
   wire [7:0]   wbyte        = hwdata[7:0];
   wire         wb_enable    = wbyte[clk_ctrl_pkg::change_enable_bit];
   wire         enable_write = wr_prescale && wb_enable && wbyte[6:0] == 7'h00;     // [RL12]
   wire         select_write = wr_prescale && !wb_enable && prescale_change_enable; // [RL11]
   wire         in_reset     = state == clk_ctrl_pkg::st_hold
                               || state == clk_ctrl_pkg::st_timeout
                               || (state == clk_ctrl_pkg::st_osc_start && !woke_from_sleep);
   wire         clocks_run   = state == clk_ctrl_pkg::st_run;

   // change enable window
   logic        next_change_enable;
   logic [2:0]  next_window;
   always_comb
   begin
      next_change_enable = prescale_change_enable;
      next_window        = window_count;
      if (select_write)
      begin
         next_change_enable = 1'b0;                                   // [RL13]
         next_window        = 3'h0;
      end
      else if (prescale_change_enable)
      begin
         next_window = window_count - 3'h1;                           // [RL14]
         if (window_count == 3'h1)
            next_change_enable = 1'b0;                                // [RL13]
      end
      else if (enable_write)
      begin
         next_change_enable = 1'b1;
         next_window        = clk_ctrl_pkg::change_window;
      end
   end

   wire [3:0]   select_reset = fuse_div8 ? clk_ctrl_pkg::select_reset_div8
                                         : clk_ctrl_pkg::select_reset_plain;     // [RL17]
   wire [3:0]   next_select  = in_reset ? select_reset
                             : select_write ? wbyte[3:0] : prescale_select;     // [RL18]
   wire [7:0]   next_trim    = in_reset ? factory_trim                          // [RL8]
                             : wr_trim ? wbyte : oscillator_trim;               // [RL9]

   // divider: new division starts only at a period boundary
   wire [7:0]   cur_mask     = div_mask(active_select);
   wire         period_end   = div_count == cur_mask;                          // [RL22]
   wire         next_pending = next_select != active_select;
   wire [3:0]   next_active  = period_end ? next_select : active_select;       // [RL22]
   wire [7:0]   next_count   = period_end ? 8'h00 : div_count + 8'h01;         // [RL16]
   wire [7:0]   next_mask    = div_mask(next_active);
   wire [7:0]   half_bit     = 8'(({1'b0, next_mask} + 9'h001) >> 1);
   wire         next_pin     = next_mask == 8'h00 ? !clock_output_pin
                             : (next_count & half_bit) == 8'h00;                // [RL3]

   // start-up sequencer
   wire [13:0]  tout_len     = timeout_len(fuse_src, fuse_sut);
   always_comb
   begin
      next_state = state;
      case (state)
         clk_ctrl_pkg::st_hold:
            if (!other_reset_active)
               next_state = tout_len == 14'h0000 ? clk_ctrl_pkg::st_osc_start
                                                 : clk_ctrl_pkg::st_timeout;  // [RL4]
         clk_ctrl_pkg::st_timeout:
            if (watchdog_osc_tick && wdt_count == tout_len - 14'h0001)
               next_state = clk_ctrl_pkg::st_osc_start;                      // [RL5]
         clk_ctrl_pkg::st_osc_start:
            if (osc_count == clk_ctrl_pkg::osc_start_cycles - 4'h1)
               next_state = clk_ctrl_pkg::st_run;                            // [RL6]
         clk_ctrl_pkg::st_run:
            if (power_down_req)
               next_state = clk_ctrl_pkg::st_sleep;
         clk_ctrl_pkg::st_sleep:
            if (wake_event)
               next_state = clk_ctrl_pkg::st_osc_start;                      // [RL7]
         default:
            next_state = clk_ctrl_pkg::st_hold;
      endcase
      if (other_reset_active)
         next_state = clk_ctrl_pkg::st_hold;
   end

   wire [7:0]   status_byte  = {1'b0, woke_from_sleep, fuse_div8, pending_change, active_select};
   wire [7:0]   read_byte    = haddr[9:0] == clk_ctrl_pkg::prescale_addr
                               ? {next_change_enable, 3'b000, next_select}     // [RL15]
                             : haddr[9:0] == clk_ctrl_pkg::trim_addr ? next_trim
                             : haddr[9:0] == clk_ctrl_pkg::status_addr ? status_byte
                             : 8'h00;
   wire         mapped_hi    = haddr[31:10] == 22'h000000;

   // bus slave
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ph_valid  <= 1'b0;
         ph_write  <= 1'b0;
         ph_addr   <= 10'h000;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         ph_valid  <= addr_phase;
         ph_write  <= addr_phase && hwrite;
         ph_addr   <= haddr[9:0];
         hrdata    <= (addr_phase && !hwrite && mapped_hi) ? {24'h000000, read_byte}
                                                           : 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // prescale and trim registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         prescale_select        <= clk_ctrl_pkg::select_reset_plain;
         prescale_change_enable <= 1'b0;
         window_count           <= 3'h0;
         oscillator_trim        <= clk_ctrl_pkg::trim_reset;
      end
      else
      begin
         prescale_select        <= next_select;
         prescale_change_enable <= next_change_enable;
         window_count           <= next_window;
         oscillator_trim        <= next_trim;
      end
   end

   // divider and clock outputs
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         active_select       <= clk_ctrl_pkg::select_reset_plain;
         pending_change      <= 1'b0;
         div_count           <= 8'h00;
         clock_output_pin    <= 1'b0;
         clock_output_pin_oe <= 1'b0;
         sys_clk_en          <= 1'b0;
      end
      else
      begin
         active_select       <= next_active;
         pending_change      <= next_pending && !period_end;
         div_count           <= next_count;
         clock_output_pin    <= clock_output_fuse && next_pin;                 // [RL2]
         clock_output_pin_oe <= clock_output_fuse;                             // [RL1]
         sys_clk_en          <= clocks_run && next_count == 8'h00;             // [RL19]
      end
   end

   // start-up sequencer and fuse sampling
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state            <= clk_ctrl_pkg::st_hold;
         wdt_count        <= 14'h0000;
         osc_count        <= 4'h0;
         fuse_src         <= 2'b00;
         fuse_sut         <= 2'b00;
         fuse_div8        <= 1'b0;
         woke_from_sleep  <= 1'b0;
         internal_reset_n <= 1'b0;
      end
      else
      begin
         state <= next_state;
         if (state == clk_ctrl_pkg::st_hold)
         begin
            fuse_src  <= clock_source_fuses;                                   // [RL23]
            fuse_sut  <= startup_time_fuses;                                   // [RL23]
            fuse_div8 <= divide_by_eight_fuse;                                 // [RL23]
         end
         if (state != clk_ctrl_pkg::st_timeout)
            wdt_count <= 14'h0000;
         else if (watchdog_osc_tick)
            wdt_count <= wdt_count + 14'h0001;                                 // [RL4]
         if (state != clk_ctrl_pkg::st_osc_start)
            osc_count <= 4'h0;
         else
            osc_count <= osc_count + 4'h1;                                     // [RL6]
         if (state == clk_ctrl_pkg::st_hold)
            woke_from_sleep <= 1'b0;
         else if (state == clk_ctrl_pkg::st_sleep && wake_event)
            woke_from_sleep <= 1'b1;                                           // [RL7]
         internal_reset_n <= !(next_state == clk_ctrl_pkg::st_hold
                               || next_state == clk_ctrl_pkg::st_timeout
                               || (next_state == clk_ctrl_pkg::st_osc_start
                                   && !(woke_from_sleep
                                        || (state == clk_ctrl_pkg::st_sleep))));
      end
   end

endmodule

// >>> verification/clock_prescale_startup_ctrl_props.sv
// assertion checker for the clock prescale and start-up block
module clock_prescale_startup_ctrl_props (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        clock_output_fuse,
   input wire logic [7:0]  factory_trim,
   input wire logic        other_reset_active,
   input wire logic        internal_reset_n,
   input wire logic        sys_clk_en,
   input wire logic        clock_output_pin,
   input wire logic        clock_output_pin_oe,
   input wire logic [7:0]  oscillator_trim
);
   logic taken;
   logic rd_pre;
   logic wr_trim;
   assign taken = hsel && hready && htrans == clk_ctrl_pkg::htrans_nonseq
      && hsize == clk_ctrl_pkg::hsize_word && haddr[31:10] == 22'h0;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_pre  <= 1'b0;
         wr_trim <= 1'b0;
      end
      else
      begin
         rd_pre  <= taken && !hwrite && haddr[9:0] == clk_ctrl_pkg::prescale_addr;
         wr_trim <= taken && hwrite && haddr[9:0] == clk_ctrl_pkg::trim_addr;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_OE_FUSE: assert property ($past(hresetn) |-> clock_output_pin_oe == $past(clock_output_fuse))
      else $error("pin enable differs from fuse");
   AST_PIN_QUIET: assert property (!clock_output_pin_oe |-> !clock_output_pin)
      else $error("pin moves while not driven");
   AST_PIN_IN_RESET: assert property ((!internal_reset_n && clock_output_pin_oe)
      |-> ##[1:10] $changed(clock_output_pin)) else $error("no clock on pin during reset");
   AST_TRIM_LOAD: assert property (!internal_reset_n |=> oscillator_trim == factory_trim)
      else $error("trim not loaded in reset");
   AST_TRIM_WRITE: assert property (wr_trim && internal_reset_n
      |=> oscillator_trim == $past(hwdata[7:0])) else $error("trim write lost");
   AST_GATED: assert property (!internal_reset_n |-> !sys_clk_en)
      else $error("system clock enable during reset");
   AST_RES_ZERO: assert property (rd_pre |-> hrdata[6:4] == 3'h0 && hrdata[31:8] == 24'h0)
      else $error("reserved prescale bits not zero");
   AST_STAY_RUN: assert property (internal_reset_n && !other_reset_active |=> internal_reset_n)
      else $error("internal reset reasserted");
   AST_OSC_HOLD: assert property ($rose(internal_reset_n) |-> $past(internal_reset_n, 6) == 1'b0)
      else $error("start count too short");
   cover property ($rose(internal_reset_n));
   cover property (wr_trim && internal_reset_n);
   cover property (rd_pre && hrdata[7]);
endmodule

bind clock_prescale_startup_ctrl clock_prescale_startup_ctrl_props u_props (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .clock_output_fuse(clock_output_fuse), .factory_trim(factory_trim),
   .other_reset_active(other_reset_active), .internal_reset_n(internal_reset_n),
   .sys_clk_en(sys_clk_en), .clock_output_pin(clock_output_pin),
   .clock_output_pin_oe(clock_output_pin_oe), .oscillator_trim(oscillator_trim));

// >>> verification/clock_output_load.sv
// external circuit sampling the clock output pad on hclk; measures its period in hclk cycles
module clock_output_load (
   input wire logic hclk,
   input wire logic pad,
   output int       rises,
   output int       period
);
   timeunit 1ns;
   timeprecision 100ps;
   int   cnt = 0;
   logic last = 1'b1;
   initial rises = 0;
   initial period = 0;
   always @(posedge hclk)
   begin
      cnt <= cnt + 1;
      last <= pad;
      if (pad && !last)
      begin
         rises  <= rises + 1;
         period <= cnt;
         cnt    <= 1;
      end
   end
endmodule

// >>> verification/clock_prescale_startup_ctrl_tb_top.sv
// self-checking bench for the clock prescale and start-up block
module clock_prescale_startup_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [31:0] pre_a  = {22'h0, clk_ctrl_pkg::prescale_addr};
   localparam logic [31:0] trim_a = {22'h0, clk_ctrl_pkg::trim_addr};
   localparam logic [31:0] stat_a = {22'h0, clk_ctrl_pkg::status_addr};
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, tick = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'h077a, rd, hrdata;
   logic [1:0]  htrans = 2'b00, cksel = 2'b00, sut = 2'b00;
   logic [2:0]  hsize = clk_ctrl_pkg::hsize_word;
   logic        fuse = 1'b0, div8 = 1'b0, orst = 1'b1, pd_req = 1'b0, wake = 1'b0;
   logic [7:0]  ftrim = 8'h00, trim;
   logic [3:0]  c;
   logic        hreadyout, hresp, irst_n, sclk_en, pin, oe, pad;
   int          rises, period, n, t, e, fails = 0, checks = 0, cyc = 0;
   assign pad = oe ? pin : 1'b1;
   clock_prescale_startup_ctrl #(.timeout_short_cycles(8), .timeout_long_cycles(16)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .clock_output_fuse(fuse),
      .clock_source_fuses(cksel), .startup_time_fuses(sut), .divide_by_eight_fuse(div8),
      .factory_trim(ftrim), .other_reset_active(orst), .watchdog_osc_tick(tick),
      .power_down_req(pd_req), .wake_event(wake), .internal_reset_n(irst_n),
      .sys_clk_en(sclk_en), .clock_output_pin(pin), .clock_output_pin_oe(oe),
      .oscillator_trim(trim));
   clock_output_load load (.hclk(hclk), .pad(pad), .rises(rises), .period(period));
   initial forever #2 hclk = ~hclk;
   always @(posedge hclk) tick <= ~tick;
   always @(posedge hclk)
   begin
      cyc = cyc + 1;
      if (cyc == 30000)
      begin
         fails = fails + 1;
         complete_run();
      end
   end
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic int exp_tout(input logic [1:0] ck, input logic [1:0] su);
      return (ck != 2'b01 && su == 2'b00) ? 0 : (ck != 2'b01 && su == 2'b01) ? 8 : 16;
   endfunction
   function automatic int exp_period(input logic [3:0] s);
      return (s == 4'h0) ? 2 : (1 << ((s > 4'h8) ? 8 : s));
   endfunction
   task automatic chk(input string name, input logic [31:0] x, input logic [31:0] g);
      checks = checks + 1;
      if (g !== x)
      begin
         fails = fails + 1;
         $display("unexpected %s expected %h seen %h", name, x, g);
      end
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= clk_ctrl_pkg::htrans_nonseq;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic complete_run();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      for (int i = 0; i < 4; i++)
      begin
         seed = next_rand(seed);
         hresetn <= 1'b0;
         orst <= 1'b1;
         fuse <= (i == 3);
         cksel <= (i == 2) ? 2'b01 : (i == 3) ? 2'b10 : 2'b00;
         sut <= (i == 3) ? 2'b10 : i[1:0];
         div8 <= i[0];
         ftrim <= seed[7:0];
         repeat (2) @(posedge hclk);
         hresetn <= 1'b1;
         repeat (3) @(posedge hclk);
         orst <= 1'b0;
         n = rises;
         e = 2 * exp_tout(cksel, sut) + 6;
         for (t = 0; irst_n !== 1'b1 && t < 200; t++) @(posedge hclk);
         chk("startup", 1, t >= e - 1 && t <= e + 4);
         chk("reset clock", fuse, rises > n);
         bus(1'b0, trim_a, 32'h0);
         chk("trim", {24'h0, ftrim}, rd);
         bus(1'b0, pre_a, 32'h0);
         chk("select reset", {30'h0, div8, div8}, rd);
      end
      bus(1'b1, pre_a, 32'h05);
      bus(1'b0, pre_a, 32'h0);
      chk("locked", 32'h03, rd);
      bus(1'b1, pre_a, 32'h81);
      bus(1'b1, pre_a, 32'h05);
      bus(1'b0, pre_a, 32'h0);
      chk("mixed enable", 32'h03, rd);
      bus(1'b1, pre_a, 32'h80);
      bus(1'b0, pre_a, 32'h0);
      chk("enable", 32'h83, rd);
      repeat (4) @(posedge hclk);
      bus(1'b0, pre_a, 32'h0);
      chk("expired", 32'h03, rd);
      bus(1'b1, pre_a, 32'h80);
      bus(1'b1, pre_a, 32'h80);
      repeat (2) @(posedge hclk);
      bus(1'b1, pre_a, 32'h05);
      bus(1'b0, pre_a, 32'h0);
      chk("no restart", 32'h03, rd);
      for (int k = 0; k <= 9; k++)
      begin
         seed = next_rand(seed);
         c = (k == 9) ? 4'h9 + 4'(seed[2:0] % 3'h7) : k[3:0];
         bus(1'b1, pre_a, 32'h80);
         bus(1'b1, pre_a, {28'h0, c});
         bus(1'b1, pre_a, {28'h0, ~c});
         bus(1'b0, pre_a, 32'h0);
         chk("select", {28'h0, c}, rd);
         n = rises;
         while (rises < n + 3) @(posedge hclk);
         chk("period", exp_period(c), period);
         t = 0;
         repeat (4 * exp_period(c)) @(posedge hclk) t += sclk_en;
         chk("pulses", (c == 4'h0) ? 8 : 4, t);
      end
      for (int k = 0; k < 3; k++)
      begin
         seed = next_rand(seed);
         e = (k == 0) ? 0 : (k == 1) ? 255 : seed[7:0];
         bus(1'b1, trim_a, e);
         bus(1'b0, trim_a, 32'h0);
         chk("trim", e, rd);
      end
      bus(1'b0, 32'h3fc, 32'h0);
      chk("unmapped", 32'h0, rd);
      bus(1'b0, stat_a, 32'h0);
      chk("fuse seen", 1, rd[5]);
      pd_req <= 1'b1;
      @(posedge hclk) pd_req <= 1'b0;
      t = 0;
      repeat (20) @(posedge hclk) t += sclk_en;
      chk("sleep gated", 0, t);
      wake <= 1'b1;
      @(posedge hclk) wake <= 1'b0;
      for (t = 0; sclk_en !== 1'b1 && t < 300; t++) @(posedge hclk);
      chk("wake", 1, t >= 6 && t <= 266);
      bus(1'b0, stat_a, 32'h0);
      chk("woke", 1, rd[6]);
      complete_run();
   end
endmodule
